// [hw/reader_cfg_regs.sv]
// Register bank for the reader's framing, checksum, speed and modulation settings.
// Assumes the checksum engine and the receive framer sit in the same clock domain.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
module reader_cfg_regs (
    input  wire logic                               clk_sys,
    input  wire logic                               srst,
    input  wire reader_cfg_pkg::reg_req_s           req,
    output logic [reader_cfg_pkg::DATA_W-1:0]       rdata,
    input  wire logic [15:0]                        checksum_value,
    input  wire logic                               checksum_done_flag,
    input  wire logic                               rx_bit_valid,
    input  wire logic                               rx_bit,
    input  wire logic                               rx_is_parity,
    input  wire logic                               rx_parity_expected,
    output logic                                    rx_data_valid,
    output logic                                    rx_data_bit,
    output logic                                    rx_parity_error,
    output reader_cfg_pkg::framing_cfg_s            framing_cfg,
    output logic                                    irq
);

    ////////////////////////////////////////////////////////////////////////////
    logic [reader_cfg_pkg::DATA_W-1:0] tx_response_wait_reg;
    logic [reader_cfg_pkg::DATA_W-1:0] rx_parity_control_reg;
    logic [reader_cfg_pkg::DATA_W-1:0] uart_speed_reg;
    logic [reader_cfg_pkg::DATA_W-1:0] modulation_pulse_width_reg;
    logic [reader_cfg_pkg::DATA_W-1:0] checksum_high_byte;
    logic [reader_cfg_pkg::DATA_W-1:0] checksum_low_byte;
    logic [reader_cfg_pkg::DATA_W-1:0] irq_status_reg;
    logic [reader_cfg_pkg::DATA_W-1:0] irq_mask_reg;
    logic [reader_cfg_pkg::DATA_W-1:0] rdata_next;
    logic [reader_cfg_pkg::DATA_W-1:0] irq_event;
    logic                              done_dly_reg;
    logic                              cfg_write;
    logic                              parity_fail;

    function automatic logic hit(input logic [reader_cfg_pkg::ADDR_W-1:0] a,
                                 input logic [reader_cfg_pkg::ADDR_W-1:0] target);
        hit = (a == target);
    endfunction : hit

    function automatic logic [reader_cfg_pkg::DATA_W-1:0] merge(input logic [reader_cfg_pkg::DATA_W-1:0] old_v,
                                                                input logic [reader_cfg_pkg::DATA_W-1:0] new_v,
                                                                input logic [reader_cfg_pkg::DATA_W-1:0] wmask);
        merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // (RULE_11) Masked writes only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_response_wait_reg  <= reader_cfg_pkg::RST_TX_RESPONSE_WAIT;
            rx_parity_control_reg <= reader_cfg_pkg::RST_RX_PARITY_CONTROL;
        end else if (req.wr) begin
            // (RULE_01) Wait field storage
            if (hit(req.addr, reader_cfg_pkg::ADDR_TX_RESPONSE_WAIT)) begin
                tx_response_wait_reg <= merge(tx_response_wait_reg, req.wdata,
                                              reader_cfg_pkg::WMASK_TX_RESPONSE_WAIT);
            end
            // (RULE_02) Parity bypass storage
            if (hit(req.addr, reader_cfg_pkg::ADDR_RX_PARITY_CONTROL)) begin
                rx_parity_control_reg <= merge(rx_parity_control_reg, req.wdata,
                                               reader_cfg_pkg::WMASK_RX_PARITY);
            end
        end
    end

    // (RULE_04) Speed factors register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            uart_speed_reg <= reader_cfg_pkg::RST_UART_SPEED;
        end else if (req.wr && hit(req.addr, reader_cfg_pkg::ADDR_UART_SPEED)) begin
            uart_speed_reg <= req.wdata;
        end
    end

    // (RULE_08) Pulse width register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            modulation_pulse_width_reg <= reader_cfg_pkg::RST_MODULATION_PULSE_WIDTH;
        end else if (req.wr && hit(req.addr, reader_cfg_pkg::ADDR_MODULATION_PULSE_WIDTH)) begin
            modulation_pulse_width_reg <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The result bytes follow the engine every cycle; validity is left to the done flag.
    // (RULE_05) Read-only result bytes
    // (RULE_06) Running high byte
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            checksum_high_byte <= reader_cfg_pkg::RST_CHECKSUM_RESULT;
            checksum_low_byte  <= reader_cfg_pkg::RST_CHECKSUM_RESULT;
        end else begin
            checksum_high_byte <= checksum_value[15:8];
            checksum_low_byte  <= checksum_value[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // (RULE_03) Parity passed as data
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_data_valid   <= 1'b0;
            rx_data_bit     <= 1'b0;
            rx_parity_error <= 1'b0;
        end else begin
            rx_data_valid   <= rx_bit_valid && (!rx_is_parity || framing_cfg.parity_bypass);
            rx_data_bit     <= rx_bit;
            rx_parity_error <= parity_fail;
        end
    end

    // (RULE_02) Check skipped on bypass
    assign parity_fail = rx_bit_valid && rx_is_parity && !framing_cfg.parity_bypass
                         && (rx_bit != rx_parity_expected);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            framing_cfg <= '0;
        end else begin
            // (RULE_01) Seven extra bits
            framing_cfg.response_wait_bits <= reader_cfg_pkg::WAIT_DEFAULT_BITS
                + 4'(tx_response_wait_reg[reader_cfg_pkg::WAIT_LSB +: reader_cfg_pkg::WAIT_W]);
            framing_cfg.parity_bypass <= rx_parity_control_reg[reader_cfg_pkg::PARITY_BYPASS_BIT];
            framing_cfg.baud_coarse_factor <= uart_speed_reg[reader_cfg_pkg::COARSE_LSB +: reader_cfg_pkg::COARSE_W];
            framing_cfg.baud_fine_factor <= uart_speed_reg[reader_cfg_pkg::FINE_LSB +: reader_cfg_pkg::FINE_W];
            // (RULE_08) Width plus one
            framing_cfg.miller_pulse_carriers <= {1'b0, modulation_pulse_width_reg} + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign cfg_write = req.wr && (hit(req.addr, reader_cfg_pkg::ADDR_TX_RESPONSE_WAIT)
                       || hit(req.addr, reader_cfg_pkg::ADDR_RX_PARITY_CONTROL)
                       || hit(req.addr, reader_cfg_pkg::ADDR_UART_SPEED)
                       || hit(req.addr, reader_cfg_pkg::ADDR_MODULATION_PULSE_WIDTH));

    always_comb begin
        irq_event = '0;
        irq_event[reader_cfg_pkg::IRQ_CHECKSUM_DONE] = checksum_done_flag && !done_dly_reg;
        irq_event[reader_cfg_pkg::IRQ_PARITY_ERROR]  = parity_fail;
        irq_event[reader_cfg_pkg::IRQ_CFG_WRITE]     = cfg_write;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done_dly_reg <= 1'b0;
        end else begin
            done_dly_reg <= checksum_done_flag;
        end
    end

    // A new event in the cycle of the clearing read survives: set wins over clear.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_status_reg <= reader_cfg_pkg::RST_IRQ;
        end else if (req.rd && hit(req.addr, reader_cfg_pkg::ADDR_IRQ_STATUS)) begin
            irq_status_reg <= irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_mask_reg <= reader_cfg_pkg::RST_IRQ;
        end else if (req.wr && hit(req.addr, reader_cfg_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_reg <= req.wdata & reader_cfg_pkg::IRQ_USED;
        end
    end

    // Registered from the status and this cycle's events so the pin is glitch free.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_status_reg | irq_event)
                      & ~((req.rd && hit(req.addr, reader_cfg_pkg::ADDR_IRQ_STATUS)) ? irq_status_reg : 8'h00))
                     & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata_next = reader_cfg_pkg::READ_UNMAPPED;
        if (hit(req.addr, reader_cfg_pkg::ADDR_TX_RESPONSE_WAIT)) begin
            rdata_next = tx_response_wait_reg;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_RX_PARITY_CONTROL)) begin
            rdata_next = rx_parity_control_reg;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_RESERVED_A)) begin
            // (RULE_10) Reserved constant values
            rdata_next = reader_cfg_pkg::RST_RESERVED_A;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_UART_SPEED)) begin
            rdata_next = uart_speed_reg;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_RESERVED_B)) begin
            rdata_next = reader_cfg_pkg::RST_RESERVED_B;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_CHECKSUM_RESULT_HIGH)) begin
            rdata_next = checksum_high_byte;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_CHECKSUM_RESULT_LOW)) begin
            rdata_next = checksum_low_byte;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_RESERVED_C)) begin
            rdata_next = reader_cfg_pkg::RST_RESERVED_C;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_MODULATION_PULSE_WIDTH)) begin
            rdata_next = modulation_pulse_width_reg;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_RESERVED_D)) begin
            rdata_next = reader_cfg_pkg::RST_RESERVED_D;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_IRQ_STATUS)) begin
            rdata_next = irq_status_reg;
        end else if (hit(req.addr, reader_cfg_pkg::ADDR_IRQ_MASK)) begin
            rdata_next = irq_mask_reg;
        end
    end

    // Read data stand only in the cycle after the strobe; zero otherwise.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata <= '0;
        end else if (req.rd) begin
            rdata <= rdata_next;
        end else begin
            rdata <= '0;
        end
    end

endmodule : reader_cfg_regs

// [hw/reader_cfg_pkg.sv]
// Constants, field layouts and carrier types for the reader configuration register bank.
// Assumes a single 40 MHz clock, synchronous active-high reset and a plain strobed register port.
//
// Overview of operation
// (RULE_01) Two-bit wait field at 1Ch adds seven bit periods to its value.
// (RULE_02) Parity bypass bit 4 at 1Dh stops parity generation and parity checking.
// (RULE_03) With bypass active the received parity bit passes on as a data bit.
// (RULE_04) Speed register 1Fh: coarse factor bits 7..5, fine bits 4..0, reset EBh.
// (RULE_05) Checksum result read-only: high byte 21h, low byte 22h, both reset FFh.
// (RULE_06) High result byte shows the running checksum's most significant byte.
// (RULE_07) Host trusts checksum bytes only while the checksum done flag is one.
// (RULE_08) Pulse width field 24h, eight bits; pulse lasts value plus one carrier periods.
// (RULE_09) Software keeps the pulse width at most half a bit period.
// (RULE_10) Addresses 1Eh, 20h, 23h, 25h reserved, reset 00h, 00h, 88h, 87h.
// (RULE_11) Writes to read-only and reserved bits change nothing; reserved bits read reset values.
package reader_cfg_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_TX_RESPONSE_WAIT       = 6'h1c;
    localparam logic [ADDR_W-1:0] ADDR_RX_PARITY_CONTROL      = 6'h1d;
    localparam logic [ADDR_W-1:0] ADDR_RESERVED_A             = 6'h1e;
    localparam logic [ADDR_W-1:0] ADDR_UART_SPEED             = 6'h1f;
    localparam logic [ADDR_W-1:0] ADDR_RESERVED_B             = 6'h20;
    localparam logic [ADDR_W-1:0] ADDR_CHECKSUM_RESULT_HIGH   = 6'h21;
    localparam logic [ADDR_W-1:0] ADDR_CHECKSUM_RESULT_LOW    = 6'h22;
    localparam logic [ADDR_W-1:0] ADDR_RESERVED_C             = 6'h23;
    localparam logic [ADDR_W-1:0] ADDR_MODULATION_PULSE_WIDTH = 6'h24;
    localparam logic [ADDR_W-1:0] ADDR_RESERVED_D             = 6'h25;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS             = 6'h3e;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK               = 6'h3f;

    localparam logic [DATA_W-1:0] RST_TX_RESPONSE_WAIT       = 8'h62;
    localparam logic [DATA_W-1:0] RST_RX_PARITY_CONTROL      = 8'h00;
    localparam logic [DATA_W-1:0] RST_RESERVED_A             = 8'h00;
    localparam logic [DATA_W-1:0] RST_UART_SPEED             = 8'heb;
    localparam logic [DATA_W-1:0] RST_RESERVED_B             = 8'h00;
    localparam logic [DATA_W-1:0] RST_CHECKSUM_RESULT        = 8'hff;
    localparam logic [DATA_W-1:0] RST_RESERVED_C             = 8'h88;
    localparam logic [DATA_W-1:0] RST_RESERVED_D             = 8'h87;
    localparam logic [DATA_W-1:0] RST_MODULATION_PULSE_WIDTH = 8'h26;
    localparam logic [DATA_W-1:0] RST_IRQ                    = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED              = 8'h00;

    // Writable bit masks; all other bits keep their reset value.
    localparam logic [DATA_W-1:0] WMASK_TX_RESPONSE_WAIT = 8'h03;
    localparam logic [DATA_W-1:0] WMASK_RX_PARITY        = 8'h10;
    localparam int PARITY_BYPASS_BIT = 4;
    localparam int WAIT_LSB          = 0;
    localparam int WAIT_W            = 2;
    localparam int COARSE_LSB        = 5;
    localparam int COARSE_W          = 3;
    localparam int FINE_LSB          = 0;
    localparam int FINE_W            = 5;

    localparam logic [3:0] WAIT_DEFAULT_BITS = 4'h7;

    // Interrupt status bit positions.
    localparam int IRQ_CHECKSUM_DONE = 0;
    localparam int IRQ_PARITY_ERROR  = 1;
    localparam int IRQ_CFG_WRITE     = 2;
    localparam logic [DATA_W-1:0] IRQ_USED = 8'h07;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    typedef struct packed {
        logic [3:0]          response_wait_bits;
        logic                parity_bypass;
        logic [COARSE_W-1:0] baud_coarse_factor;
        logic [FINE_W-1:0]   baud_fine_factor;
        logic [8:0]          miller_pulse_carriers;
    } framing_cfg_s;

endpackage : reader_cfg_pkg

// [tb/reader_cfg_regs_chk.sv]
// Concurrent checks on the ports of the reader configuration register bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module reader_cfg_regs_chk (
    input wire logic                         clk_sys,
    input wire logic                         srst,
    input wire reader_cfg_pkg::reg_req_s     req,
    input wire logic [7:0]                   rdata,
    input wire logic [15:0]                  checksum_value,
    input wire logic                         rx_bit_valid,
    input wire logic                         rx_bit,
    input wire logic                         rx_is_parity,
    input wire logic                         rx_parity_expected,
    input wire logic                         rx_data_valid,
    input wire logic                         rx_data_bit,
    input wire logic                         rx_parity_error,
    input wire reader_cfg_pkg::framing_cfg_s framing_cfg,
    input wire logic                         irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    // The request comes in as an argument so that its sampled value is used, not the value the bench just drove.
    function automatic logic rd_at(input reader_cfg_pkg::reg_req_s r, input logic [5:0] a);
        return r.rd && r.addr == a;
    endfunction : rd_at

    ////////////////////////////////////////////////////////////////////////////
    // Derived settings are compared with the stored value returned by a read.
    chk_wait_add_seven: assert property (rd_at(req, 6'h1c) |=> framing_cfg.response_wait_bits == 4'h7 + rdata[1:0])
        else $error("wait extension mismatch");
    chk_bypass_follows: assert property (rd_at(req, 6'h1d) |=> framing_cfg.parity_bypass == rdata[4])
        else $error("parity bypass mismatch");
    chk_speed_fields: assert property (rd_at(req, 6'h1f) |=> {framing_cfg.baud_coarse_factor, framing_cfg.baud_fine_factor} == rdata)
        else $error("speed factors mismatch");
    chk_pulse_plus_one: assert property (rd_at(req, 6'h24) |=> framing_cfg.miller_pulse_carriers == rdata + 9'h001)
        else $error("pulse width mismatch");
    chk_result_high: assert property (rd_at(req, 6'h21) |=> rdata == 8'($past(checksum_value, 2) >> 8))
        else $error("checksum high byte mismatch");
    chk_result_low: assert property (rd_at(req, 6'h22) |=> rdata == 8'($past(checksum_value, 2)))
        else $error("checksum low byte mismatch");
    chk_rsvd_fixed: assert property (rd_at(req, 6'h23) || rd_at(req, 6'h25) |=> rdata == ($past(req.addr) == 6'h23 ? 8'h88 : 8'h87))
        else $error("reserved value mismatch");
    chk_rsvd_bits: assert property (rd_at(req, 6'h1d) |=> (rdata & 8'hef) == 8'h00)
        else $error("reserved bits not zero");
    chk_rdata_quiet: assert property (!req.rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");

    ////////////////////////////////////////////////////////////////////////////
    chk_parity_flagged: assert property (rx_bit_valid && rx_is_parity && !framing_cfg.parity_bypass
        |=> !rx_data_valid && rx_parity_error == $past(rx_bit ^ rx_parity_expected))
        else $error("parity check wrong");
    chk_bypass_passes: assert property (rx_bit_valid && rx_is_parity && framing_cfg.parity_bypass
        |=> rx_data_valid && !rx_parity_error && rx_data_bit == $past(rx_bit))
        else $error("bypassed parity not forwarded");
    chk_data_forward: assert property (rx_bit_valid && !rx_is_parity |=> rx_data_valid && rx_data_bit == $past(rx_bit))
        else $error("data bit not forwarded");

    cover property (rx_parity_error);
    cover property (irq);
    cover property (req.wr && req.addr == 6'h24);
endmodule : reader_cfg_regs_chk

// [tb/testbench.sv]
// Self-checking bench for the reader configuration register bank.
// Assumes a 40 MHz clock; the bench drives every design input itself.
`timescale 1ns/10ps
module testbench;
    logic                         clk_sys = 1'b0;
    logic                         srst = 1'b1;
    reader_cfg_pkg::reg_req_s     req = '0;
    logic [7:0]                   rdata;
    logic [15:0]                  checksum_value = 16'hffff;
    logic                         checksum_done_flag = 1'b0;
    logic                         rx_bit_valid = 1'b0;
    logic                         rx_bit = 1'b0;
    logic                         rx_is_parity = 1'b0;
    logic                         rx_parity_expected = 1'b0;
    logic                         rx_data_valid;
    logic                         rx_data_bit;
    logic                         rx_parity_error;
    reader_cfg_pkg::framing_cfg_s framing_cfg;
    logic                         irq;
    int                           errors = 0;
    int                           samples_checked = 0;
    int                           cycles = 0;
    logic [7:0]                   v;
    logic [7:0]                   rst_t [10] = '{8'h62, 8'h00, 8'h00, 8'heb, 8'h00, 8'hff, 8'hff, 8'h88, 8'h26, 8'h87};
    logic [7:0]                   wm_t [10] = '{8'h03, 8'h10, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    logic [7:0]                   pat [2] = '{8'hff, 8'h00};
    logic [21:0]                  fexp [2] = '{{4'ha, 1'b1, 3'h7, 5'h1f, 9'h100}, {4'h7, 1'b0, 3'h0, 5'h00, 9'h001}};

    always #12.5 clk_sys = ~clk_sys;

    reader_cfg_regs uut (.clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
        .checksum_value(checksum_value), .checksum_done_flag(checksum_done_flag),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_is_parity(rx_is_parity),
        .rx_parity_expected(rx_parity_expected), .rx_data_valid(rx_data_valid), .rx_data_bit(rx_data_bit),
        .rx_parity_error(rx_parity_error), .framing_cfg(framing_cfg), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [21:0] seen, input logic [21:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // A write leaves its strobe up; the caller idles the bus after a burst.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
    endtask : wr

    task automatic idle();
        req <= '0;
        @(posedge clk_sys);
    endtask : idle

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        req <= '0;
        #1 d = rdata;
        @(posedge clk_sys);
    endtask : rd

    // Expected triple is valid, parity error, forwarded bit.
    task automatic rx(input logic b, input logic par, input logic mis, input logic [2:0] exp);
        rx_bit_valid <= 1'b1;
        rx_bit <= b;
        rx_is_parity <= par;
        rx_parity_expected <= b ^ mis;
        @(posedge clk_sys);
        rx_bit_valid <= 1'b0;
        #1 check("rx", {rx_data_valid, rx_parity_error, rx_data_bit}, exp);
        @(posedge clk_sys);
    endtask : rx

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            rd(6'h1c + 6'(i), v);
            check("reset value", v, rst_t[i]);
        end
        rd(6'h10, v);
        check("unmapped", v, 8'h00);
        // Back-to-back writes of all ones, then all zeros, across the whole range.
        foreach (pat[p]) begin
            for (int i = 0; i < 10; i++) wr(6'h1c + 6'(i), pat[p]);
            idle();
            for (int i = 0; i < 10; i++) begin
                rd(6'h1c + 6'(i), v);
                check("readback", v, (rst_t[i] & ~wm_t[i]) | (pat[p] & wm_t[i]));
            end
            check("framing", framing_cfg, fexp[p]);
        end
        wr(6'h3f, 8'h00);
        rd(6'h3e, v);
        rx(1'b1, 1'b0, 1'b0, 3'b101);
        rx(1'b1, 1'b1, 1'b1, 3'b011);
        rx(1'b0, 1'b1, 1'b0, 3'b000);
        check("irq masked", irq, 1'b0);
        wr(6'h3f, 8'h02);
        repeat (2) idle();
        check("irq raised", irq, 1'b1);
        rd(6'h3e, v);
        check("irq status", v & 8'h02, 8'h02);
        repeat (2) idle();
        check("irq cleared", irq, 1'b0);
        wr(6'h1d, 8'h10);
        repeat (2) idle();
        rx(1'b0, 1'b1, 1'b1, 3'b100);
        // Result bytes are only trusted once the done flag is up.
        wr(6'h3f, 8'h01);
        rd(6'h3e, v);
        checksum_value <= 16'ha55a;
        checksum_done_flag <= 1'b1;
        repeat (3) idle();
        check("done irq", irq, 1'b1);
        rd(6'h21, v);
        check("checksum high", v, 8'ha5);
        rd(6'h22, v);
        check("checksum low", v, 8'h5a);
        // Configuration writes raise status bit 2; the width chosen stays well inside half a bit period.
        wr(6'h3f, 8'h04);
        rd(6'h3e, v);
        wr(6'h24, 8'h1f);
        repeat (2) idle();
        check("cfg write irq", irq, 1'b1);
        rd(6'h3e, v);
        check("cfg write status", v, 8'h04);
        check("pulse carriers", framing_cfg.miller_pulse_carriers, 9'h020);
        // A reset in mid-run clears the derived settings, which come back one cycle after release.
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("framing in reset", framing_cfg, 22'h0);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("framing after reset", framing_cfg, {4'h9, 1'b0, 3'h7, 5'h0b, 9'h027});
        report_and_stop();
    end
endmodule : testbench

bind reader_cfg_regs reader_cfg_regs_chk chk_i (.clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
    .checksum_value(checksum_value), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_is_parity(rx_is_parity),
    .rx_parity_expected(rx_parity_expected), .rx_data_valid(rx_data_valid), .rx_data_bit(rx_data_bit),
    .rx_parity_error(rx_parity_error), .framing_cfg(framing_cfg), .irq(irq));
